// file: lcd_panel_video_timing.v
// Video timing generator that drives the 800x480 parallel RGB panel
//
// Overview of operation
// - Pixel bus is 24 bits, red green blue, one dot per clock.
// - Dot clock about 33 MHz, high phase 40 to 60 percent.
// - Enable mode: line is 1056 clocks, 800 valid, 256 blank.
// - Enable mode: frame is 525 lines, 480 valid, 45 blank.
// - Sync mode: line is 1056 clocks, line sync 30 clocks first.
// - Sync mode: back porch 16, sync plus porch fixed at 46.
// - Sync mode: 800 visible dots then front porch of 210.
// - Sync mode: frame is 525 lines, frame sync 13 lines first.
// - Sync mode: vertical back porch 10, sync plus porch 23.
// - Sync mode: 480 visible lines then front porch of 22.
// - Timing source select is held constant by the driver; reset drives it to 0 even in sync mode.
// - Line sync marks the start of each line period.
// - Frame sync marks the start of each frame period.
// - Backlight enable is separate from pixel timing.
`timescale 1ns/100ps
`include "panel_timing_regs.vh"
module lcd_panel_video_timing #(
  parameter PIX_W = `PIX_W,
  parameter SYNC_MODE = 0,
  parameter V_SYNC_LINES = `V_SYNC,
  parameter V_BACK_LINES = `V_BACK
) (
  clk,
  rst,
  pixelIn,
  backlightReq,
  pixelReady,
  pixelX,
  pixelY,
  frameStart,
  panelDotClockPin,
  pixelOut,
  pixelValidIn,
  lineSyncIn_n,
  frameSyncIn_n,
  timingSourceSelect,
  backlightOn
);
  input wire clk;
  input wire rst;
  input wire [PIX_W-1:0] pixelIn;
  input wire backlightReq;
  output reg pixelReady;
  output reg [10:0] pixelX;
  output reg [9:0] pixelY;
  output reg frameStart;
  output reg panelDotClockPin;
  output reg [PIX_W-1:0] pixelOut;
  output reg pixelValidIn;
  output reg lineSyncIn_n;
  output reg frameSyncIn_n;
  output reg timingSourceSelect;
  output reg backlightOn;

  // ****************************************************
  // Counters
  // ****************************************************
  localparam [10:0] HPER = `H_PERIOD;
  localparam [10:0] HSYN = `H_SYNC;
  localparam [10:0] HSTART = `H_SYNC + `H_BACK;
  localparam [10:0] HEND = `H_SYNC + `H_BACK + `H_VALID;
  localparam [9:0] VPER = `V_PERIOD;
  localparam [9:0] VSYN = V_SYNC_LINES;
  localparam [9:0] VSTART = V_SYNC_LINES + V_BACK_LINES;
  localparam [9:0] VEND = V_SYNC_LINES + V_BACK_LINES + `V_VALID;

  wire dotClk;
  wire riseTick;
  wire fallTick;
  reg [10:0] hCnt_q;
  reg [9:0] vCnt_q;
  reg dotClk_q;
  reg fallDly1_q;
  reg fallDly2_q;
  reg fallDly3_q;

  dot_clock_div #(.DIV(`DOT_DIV)) divider (
    .clk(clk),
    .rst(rst),
    .dotClk(dotClk),
    .riseTick(riseTick),
    .fallTick(fallTick)
  );

  // Both modes share one counter layout: visible window sits at 46..845
  // horizontally and 23..502 vertically, so enable mode sees 800/256 and
  // 480/45 as well, and switching the select never moves the picture.
  function inWin11;
    input [10:0] c;
    input [10:0] lo;
    input [10:0] hi;
    begin
      inWin11 = (c >= lo) && (c < hi);
    end
  endfunction

  wire hAct = inWin11(hCnt_q, HSTART, HEND);
  wire vAct = (vCnt_q >= VSTART) && (vCnt_q < VEND);
  wire active = hAct && vAct;

  // ****************************************************
  // Timing and pins
  // ****************************************************
  always @(posedge clk) begin
    if (rst) begin
      hCnt_q <= 11'h000;
      vCnt_q <= 10'h000;
      dotClk_q <= 1'b0;
      fallDly1_q <= 1'b0;
      fallDly2_q <= 1'b0;
      fallDly3_q <= 1'b0;
      panelDotClockPin <= 1'b0;
      pixelOut <= {PIX_W{1'b0}};
      pixelValidIn <= 1'b0;
      lineSyncIn_n <= 1'b1;
      frameSyncIn_n <= 1'b1;
      timingSourceSelect <= 1'b0;
      backlightOn <= 1'b0;
      pixelReady <= 1'b0;
      pixelX <= 11'h000;
      pixelY <= 10'h000;
      frameStart <= 1'b0;
    end else begin
      dotClk_q <= dotClk;
      panelDotClockPin <= dotClk_q;
      timingSourceSelect <= (SYNC_MODE != 0);
      backlightOn <= backlightReq;
      pixelReady <= 1'b0;
      frameStart <= 1'b0;
      // The pin lags the divider by two flops, so the launch tick is
      // delayed three clocks to land two clocks after the pin falls,
      // in the middle of the low phase; the panel samples on the rise.
      fallDly1_q <= fallTick;
      fallDly2_q <= fallDly1_q;
      fallDly3_q <= fallDly2_q;
      if (fallDly3_q) begin
        if (hCnt_q == HPER - 11'h001) begin
          hCnt_q <= 11'h000;
          vCnt_q <= (vCnt_q == VPER - 10'h001) ? 10'h000
                    : vCnt_q + 10'h001;
        end else begin
          hCnt_q <= hCnt_q + 11'h001;
        end
        pixelValidIn <= active;
        pixelOut <= active ? pixelIn : {PIX_W{1'b0}};
        lineSyncIn_n <= ~(hCnt_q < HSYN);
        frameSyncIn_n <= ~(vCnt_q < VSYN);
        pixelReady <= active;
        pixelX <= hAct ? hCnt_q - HSTART : 11'h000;
        pixelY <= vAct ? vCnt_q - VSTART : 10'h000;
        frameStart <= (hCnt_q == 11'h000) && (vCnt_q == 10'h000);
      end
    end
  end
endmodule // lcd_panel_video_timing

// file: panel_timing_regs.vh
// Timing constants for the 800x480 panel video timing generator
`ifndef PANEL_TIMING_REGS_VH
`define PANEL_TIMING_REGS_VH

// Horizontal, in dot clocks
`define H_PERIOD 1056
`define H_VALID 800
`define H_BLANK 256
`define H_SYNC 30
`define H_BACK 16
`define H_FRONT 210
// Vertical, in lines
`define V_PERIOD 525
`define V_VALID 480
`define V_BLANK 45
`define V_SYNC 13
`define V_BACK 10
`define V_FRONT 22
// Dot clock divider: 250 MHz / 8 = 31.25 MHz, nearest even split to 33 MHz
`define DOT_DIV 8
`define PIX_W 24

`endif

// file: dot_clock_div.v
// Dot clock divider with half-period phase pulses
`timescale 1ns/100ps
`include "panel_timing_regs.vh"
module dot_clock_div #(
  parameter DIV = `DOT_DIV
) (
  clk,
  rst,
  dotClk,
  riseTick,
  fallTick
);
  input wire clk;
  input wire rst;
  output reg dotClk;
  output reg riseTick;
  output reg fallTick;

  reg [7:0] cnt_q;
  localparam [7:0] HALF = DIV / 2;
  localparam [7:0] LAST = DIV - 1;

  // Even divider gives an exact 50 percent duty
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      dotClk <= 1'b0;
      riseTick <= 1'b0;
      fallTick <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == LAST) ? 8'h00 : cnt_q + 8'h01;
      riseTick <= (cnt_q == LAST);
      fallTick <= (cnt_q == HALF - 8'h01);
      if (cnt_q == LAST) begin
        dotClk <= 1'b1;
      end else if (cnt_q == HALF - 8'h01) begin
        dotClk <= 1'b0;
      end
    end
  end
endmodule // dot_clock_div

// file: lcd_panel_video_timing_props.sv
// Timing checker for the panel video timing generator
`timescale 1ns/100ps
module panel_timing_checker #(parameter PIX_W = 24) (
  input wire clk,
  input wire rst,
  input wire panelDotClockPin,
  input wire [PIX_W-1:0] pixelOut,
  input wire pixelValidIn,
  input wire lineSyncIn_n,
  input wire frameSyncIn_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [13:0] hc_q;
  logic seen_q;
  sequence dotHigh; panelDotClockPin[*3]; endsequence
  sequence dotLow; !panelDotClockPin[*4]; endsequence
  // Clocks since line sync fell; first line after reset has no period
  always @(posedge clk) begin
    hc_q <= $fell(lineSyncIn_n) ? 14'h0000 : hc_q + 14'h0001;
    seen_q <= !rst && (seen_q || $fell(lineSyncIn_n));
  end
  a_hsync_width: assert property
    ($rose(lineSyncIn_n) |-> hc_q == 14'h00EF) else $error("sync width");
  a_line_period: assert property
    (seen_q && $fell(lineSyncIn_n) |-> hc_q == 14'h20FF) else $error("period");
  a_valid_start: assert property
    ($rose(pixelValidIn) |-> hc_q == 14'h016F) else $error("valid start");
  a_valid_end: assert property
    ($fell(pixelValidIn) |-> hc_q == 14'h1A6F) else $error("valid end");
  a_dot_duty: assert property
    ($rose(panelDotClockPin) |=> dotHigh ##1 dotLow) else $error("duty");
  a_launch_low: assert property
    ($changed(pixelValidIn) |-> !panelDotClockPin ##1 !panelDotClockPin)
    else $error("launch phase");
  a_frame_align: assert property
    ($fell(frameSyncIn_n) |-> $fell(lineSyncIn_n)) else $error("frame");
  a_black_blank: assert property
    (!pixelValidIn |-> pixelOut == '0) else $error("not black");
endmodule // panel_timing_checker
bind lcd_panel_video_timing panel_timing_checker #(.PIX_W(PIX_W)) u_chk (
  .clk(clk), .rst(rst), .panelDotClockPin(panelDotClockPin),
  .pixelOut(pixelOut), .pixelValidIn(pixelValidIn),
  .lineSyncIn_n(lineSyncIn_n), .frameSyncIn_n(frameSyncIn_n));

// file: panel_model.sv
// Behavioural panel that takes dots on the rising dot clock
`timescale 1ns/100ps
module panel_model (
  input wire dotPin,
  input wire [23:0] pix,
  input wire valid,
  input wire hs_n,
  input wire vs_n,
  output logic [10:0] dots,
  output logic [23:0] lastPix,
  output logic [4:0] vsLines
);
  logic [10:0] cnt;
  logic prevHs;
  initial begin
    {dots, cnt, vsLines, prevHs} = 28'h0000001;
  end
  always @(posedge dotPin) begin
    prevHs <= hs_n;
    if (valid) begin
      cnt <= cnt + 11'h001;
      lastPix <= pix;
    end else if (cnt != 11'h000) begin
      dots <= cnt;
      cnt <= 11'h000;
    end
    if (prevHs && !hs_n && !vs_n)
      vsLines <= vsLines + 5'h01;
  end
endmodule // panel_model

// file: lcd_panel_video_timing_bench.sv
// Self-checking bench for the panel video timing generator
`timescale 1ns/100ps
module lcd_panel_video_timing_bench;
  logic clk, rst, backlightReq, dotPin, valid, hs_n, vs_n, sel, blOn;
  logic [23:0] pixelIn, pixelOut, lastPix;
  logic [10:0] dots;
  logic [4:0] vsLines;
  logic rdy, fs;
  logic fsSeen = 1'b0;
  logic [10:0] px, lastX;
  logic [9:0] py, lastY;
  always @(posedge clk) begin
    if (rdy) begin
      lastX <= px;
      lastY <= py;
    end
    if (fs) fsSeen <= 1'b1;
  end
  integer bad_count = 0;
  integer comparisons = 0;
  // Short vertical lead keeps the first visible line within the run budget
  lcd_panel_video_timing #(.V_SYNC_LINES(2), .V_BACK_LINES(1))
    u_lcd_panel_video_timing (.clk(clk), .rst(rst),
    .pixelIn(pixelIn), .backlightReq(backlightReq), .pixelReady(rdy),
    .pixelX(px), .pixelY(py), .frameStart(fs), .panelDotClockPin(dotPin),
    .pixelOut(pixelOut), .pixelValidIn(valid), .lineSyncIn_n(hs_n),
    .frameSyncIn_n(vs_n), .timingSourceSelect(sel), .backlightOn(blOn));
  panel_model u_panel_model (.dotPin(dotPin), .pix(pixelOut),
    .valid(valid), .hs_n(hs_n), .vs_n(vs_n), .dots(dots),
    .lastPix(lastPix), .vsLines(vsLines));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic sc_reset;
    chk({hs_n, vs_n, valid, pixelOut}, 32'h06000000);
  endtask
  task automatic sc_backlight;
    backlightReq = 1'b1;
    repeat (2) @(negedge clk);
    chk(blOn, 32'h00000001);
    backlightReq = 1'b0;
    repeat (2) @(negedge clk);
    chk(blOn, 32'h00000000);
    chk(sel, 32'h00000000);
  endtask
  // Waits past the 3 lead lines; the first visible line ends the wait
  task automatic sc_frame;
    integer n;
    for (n = 0; n < 60000 && dots == 11'h000; n++) @(negedge clk);
    if (dots == 11'h000) begin
      bad_count = bad_count + 1;
      results();
    end
    chk(dots, 32'h00000320);
    chk(lastPix, 32'h00C35A1E);
    chk(vsLines, 32'h00000002);
    chk(lastX, 32'h0000031F);
    chk(lastY, 32'h00000000);
    chk(fsSeen, 32'h00000001);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    backlightReq = 1'b0;
    pixelIn = 24'hC35A1E;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    sc_reset();
    sc_backlight();
    sc_frame();
    results();
  end
endmodule // lcd_panel_video_timing_bench
